// [core/pmw_device.sv]
// Device end: modes, pin reset, wake request, global interrupt, general pins.
// Assumes the host keeps pin reset waits and drives test inputs.
`timescale 1ns/1ns
`include "pmw_consts.svh"
module pmw_device import pmw_pkg::*; #(
  parameter int RST_MIN_PULSE = `PMW_RST_MIN_PULSE
) (
  input wire logic clock,
  input wire logic rst_n,
  pmw_if.device pins,
  input wire logic bus_wake_pattern,
  input wire logic local_wake_flag,
  input wire logic wake_error_flag,
  input wire logic [3:0] fault_a,
  input wire logic [7:0] fault_b,
  input wire logic ctrl_irq_n,
  input wire logic wd_expire,
  input wire logic logic_io_supply,
  input wire logic xcvr_rx_out,
  input wire logic core_tx_out,
  output pmw_mode_t mode,
  output logic test_en,
  output logic xcvr_tx_in,
  output logic core_rx_in,
  output logic [1:0] watchdog_action_sel,
  output logic watchdog_kick_bit
);
  logic rst_s, rst_prev, irq_s, gio_s, gio_prev, vio_s, fire;
  logic [7:0] pulse_cnt;
  logic [31:0] cfg, stat_a, stat_b, mask_a, mask_b;
  logic wake_latch, acc, wr, rd, wake_in, sleep_entry;
  logic [3:0] wake_bits;
  logic wkrq_on, irq_on, gpa_val, gpb_val;
  pmw_mode_t next_mode;

  // ==========================================
  // Pin synchronisers
  pmw_sync #(.W(4), .INIT(4'h7)) u_sync ( // Idle levels: pin reset low, pulled-up pins high
    .clock(clock),
    .rst_n(rst_n),
    .d({pins.rst_pin, pins.irq_level, pins.gio_a_level, logic_io_supply}),
    .q({rst_s, irq_s, gio_s, vio_s})
  );

  // Register access, refused while asleep
  assign acc = (mode != PMW_SLEEP);
  assign wr = pins.reg_wr & acc;
  assign rd = pins.reg_rd & acc;
  assign wake_in = bus_wake_pattern | local_wake_flag;
  assign sleep_entry = (next_mode == PMW_SLEEP) && (mode != PMW_SLEEP);

  // ==========================================
  // Pin reset pulse width filter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt <= 8'h00;
      rst_prev <= 1'b0;
      fire <= 1'b0;
    end else begin
      rst_prev <= rst_s;
      fire <= rst_prev & ~rst_s & (32'(pulse_cnt) >= RST_MIN_PULSE);
      if (!rst_s) begin
        pulse_cnt <= 8'h00;
      end else if (32'(pulse_cnt) < RST_MIN_PULSE) begin
        pulse_cnt <= pulse_cnt + 8'h01;
      end
    end
  end

  // ==========================================
  // Mode selection
  always_comb begin
    next_mode = mode;
    if (fire) begin
      next_mode = PMW_STANDBY;
    end else if (cfg[`PMW_B_TEST_EN] && !cfg[`PMW_B_TEST_SEL]) begin
      next_mode = irq_s ? PMW_NORMAL : PMW_STANDBY;
    end else begin
      case (mode)
        PMW_SLEEP: begin
          if (wake_in) begin
            next_mode = PMW_STANDBY;
          end
        end
        default: begin
          if (wr && pins.reg_addr == `PMW_MODE_OFF) begin
            case (pins.reg_wdata[1:0])
              2'h0: next_mode = PMW_STANDBY;
              2'h1: next_mode = PMW_NORMAL;
              2'h3: next_mode = PMW_SLEEP;
              default: next_mode = mode;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= PMW_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================
  // Configuration and masks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= `PMW_CFG_RST;
      mask_a <= 32'h0000_0000;
      mask_b <= 32'h0000_0000;
    end else if (fire) begin
      cfg <= `PMW_CFG_RST;
      mask_a <= 32'h0000_0000;
      mask_b <= 32'h0000_0000;
    end else if (sleep_entry) begin
      cfg <= `PMW_CFG_RST | (cfg & (32'h1 << `PMW_B_WK_VIO));
      mask_a <= 32'h0000_0000;
      mask_b <= 32'h0000_0000;
    end else if (wr) begin
      if (pins.reg_addr == `PMW_CFG_OFF) begin
        cfg <= pins.reg_wdata & ~(32'h1 << `PMW_B_WD_KICK); // Kick bit self clears
      end
      if (pins.reg_addr == `PMW_MASK_A_OFF) begin
        mask_a <= pins.reg_wdata;
      end
      if (pins.reg_addr == `PMW_MASK_B_OFF) begin
        mask_b <= pins.reg_wdata;
      end
    end
  end

  // ==========================================
  // Status flags, write one to clear, set wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_a <= `PMW_STAT_A_RST;
      stat_b <= 32'h0000_0000;
    end else if (fire) begin
      stat_a <= `PMW_STAT_A_RST;
      stat_b <= 32'h0000_0000;
    end else if (sleep_entry) begin
      stat_a <= 32'h0000_0000;
      stat_b <= 32'h0000_0000;
    end else begin
      stat_a <= (stat_a & ~((wr && pins.reg_addr == `PMW_STAT_A_OFF) ? pins.reg_wdata : 32'h0))
        | (32'(bus_wake_pattern) << `PMW_B_BUS_WAKE)
        | (32'(local_wake_flag) << `PMW_B_LOCAL_WAKE)
        | (32'(wake_error_flag) << `PMW_B_WAKE_ERR)
        | (32'(fault_a) << `PMW_B_FAULT_A);
      stat_b <= (stat_b & ~((wr && pins.reg_addr == `PMW_STAT_B_OFF) ? pins.reg_wdata : 32'h0))
        | 32'(fault_b);
    end
  end

  // ==========================================
  // Wake request latch
  assign wake_bits = stat_a[3:0] & ~mask_a[3:0];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_latch <= 1'b1;
    end else if (fire) begin
      wake_latch <= 1'b1;
    end else if (sleep_entry) begin
      wake_latch <= 1'b0;
    end else if (|wake_bits) begin
      wake_latch <= 1'b1;
    end
  end

  // ==========================================
  // Pin functions
  assign irq_on = (|(stat_a & ~mask_a)) | (|(stat_b & ~mask_b));
  assign wkrq_on = (cfg[`PMW_B_WK_IRQ] ? (|wake_bits) : wake_latch)
    & (~cfg[`PMW_B_WK_VIO] | vio_s);

  // Pin A output function
  always_comb begin
    case (cfg[`PMW_B_GPA_FN +: 2])
      2'h0: gpa_val = ctrl_irq_n;
      2'h1: gpa_val = ~wd_expire;
      2'h2: gpa_val = ~irq_on;
      default: gpa_val = 1'b1;
    endcase
  end

  // Pin B selected interrupts
  always_comb begin
    case (cfg[`PMW_B_GPB_FN +: 2])
      2'h0: gpb_val = ctrl_irq_n;
      2'h1: gpb_val = ~wd_expire;
      2'h2: gpb_val = ~irq_on;
      default: gpb_val = ~(|wake_bits);
    endcase
  end

  // Pin drivers, all registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pins.wkrq_out <= 1'b0;
      pins.wkrq_oe <= 1'b1;
      pins.irq_out <= 1'b1;
      pins.irq_oe <= 1'b0;
      pins.gio_a_out <= 1'b1;
      pins.gio_a_oe <= 1'b1;
      pins.gpo_b_out <= 1'b1;
      pins.gpo_b_oe <= 1'b0;
      pins.regulator_enable_out <= 1'b1;
    end else begin
      pins.wkrq_out <= ~wkrq_on;
      pins.wkrq_oe <= cfg[`PMW_B_WK_VIO] ? wkrq_on : 1'b1;
      pins.irq_out <= 1'b0;
      pins.irq_oe <= irq_on & (next_mode != PMW_SLEEP)
        & ~(cfg[`PMW_B_TEST_EN] & ~cfg[`PMW_B_TEST_SEL]);
      pins.regulator_enable_out <= (next_mode != PMW_SLEEP) & ~cfg[`PMW_B_INH_DIS];
      if (cfg[`PMW_B_TEST_EN]) begin
        pins.gio_a_oe <= 1'b0;
        pins.gio_a_out <= 1'b1;
        pins.gpo_b_out <= 1'b0;
        pins.gpo_b_oe <= ~(cfg[`PMW_B_TEST_SEL] ? core_tx_out : xcvr_rx_out);
      end else begin
        case (cfg[`PMW_B_GPA_MODE +: 2])
          2'h0: pins.gio_a_out <= gpa_val;
          2'h1: pins.gio_a_out <= ctrl_irq_n;
          default: pins.gio_a_out <= 1'b1;
        endcase
        pins.gio_a_oe <= (cfg[`PMW_B_GPA_MODE +: 2] != 2'h2);
        pins.gpo_b_out <= 1'b0;
        pins.gpo_b_oe <= ~gpb_val & (next_mode != PMW_SLEEP);
      end
    end
  end

  // ==========================================
  // Test routing and watchdog controls
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      test_en <= 1'b0;
      xcvr_tx_in <= 1'b1;
      core_rx_in <= 1'b1;
      watchdog_action_sel <= 2'h0;
      watchdog_kick_bit <= 1'b0;
      gio_prev <= 1'b1;
    end else begin
      gio_prev <= gio_s;
      test_en <= cfg[`PMW_B_TEST_EN];
      xcvr_tx_in <= (cfg[`PMW_B_TEST_EN] & ~cfg[`PMW_B_TEST_SEL]) ? gio_s : 1'b1;
      core_rx_in <= (cfg[`PMW_B_TEST_EN] & cfg[`PMW_B_TEST_SEL]) ? gio_s : 1'b1;
      watchdog_action_sel <= cfg[`PMW_B_TEST_EN] ? {1'b0, cfg[`PMW_B_WD_ACT]}
        : cfg[`PMW_B_WD_ACT +: 2];
      watchdog_kick_bit <= (wr && pins.reg_addr == `PMW_CFG_OFF
        && pins.reg_wdata[`PMW_B_WD_KICK])
        | (~cfg[`PMW_B_TEST_EN] && cfg[`PMW_B_GPA_MODE +: 2] == 2'h2
        && gio_prev && !gio_s);
    end
  end

  // ==========================================
  // Read data, one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pins.reg_rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (pins.reg_addr)
        `PMW_CFG_OFF: pins.reg_rdata <= cfg;
        `PMW_MODE_OFF: pins.reg_rdata <= {30'h0, mode};
        `PMW_STAT_A_OFF: pins.reg_rdata <= stat_a;
        `PMW_STAT_B_OFF: pins.reg_rdata <= stat_b;
        `PMW_MASK_A_OFF: pins.reg_rdata <= mask_a;
        `PMW_MASK_B_OFF: pins.reg_rdata <= mask_b;
        default: pins.reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      pins.reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // pmw_device

// [inc/pmw_consts.svh]
// Constants of the pin, mode and wake control block and its host end.
// Assumes a 10 MHz clock shared by both ends.
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH
// ==========================================
// Device register offsets
`define PMW_CFG_OFF 16'h0800
`define PMW_MODE_OFF 16'h0810
`define PMW_STAT_A_OFF 16'h0820
`define PMW_STAT_B_OFF 16'h0824
`define PMW_MASK_A_OFF 16'h0830
`define PMW_MASK_B_OFF 16'h0834
// ==========================================
// Configuration fields
`define PMW_B_TEST_SEL 0
`define PMW_B_WK_IRQ 8
`define PMW_B_INH_DIS 9
`define PMW_B_GPA_FN 10
`define PMW_B_GPA_MODE 14
`define PMW_B_WD_ACT 16
`define PMW_B_WD_KICK 18
`define PMW_B_WK_VIO 19
`define PMW_B_TEST_EN 21
`define PMW_B_GPB_FN 22
`define PMW_CFG_RST 32'h0000_4000
// ==========================================
// Status fields
`define PMW_B_BUS_WAKE 0
`define PMW_B_LOCAL_WAKE 1
`define PMW_B_WAKE_ERR 2
`define PMW_B_PWR_ON 3
`define PMW_B_FAULT_A 8
`define PMW_STAT_A_RST 32'h0000_0008
// ==========================================
// Timing
`define PMW_CLK_MHZ 10
`define PMW_RST_MIN_PULSE 4
`define PMW_HOST_PULSE 8
`define PMW_RST_WAIT_US 700
`define PMW_RST_WAIT_CYC (`PMW_RST_WAIT_US * `PMW_CLK_MHZ)
// ==========================================
// Host command port offsets
`define PMW_H_ADDR 8'h00
`define PMW_H_WDATA 8'h04
`define PMW_H_CMD 8'h08
`define PMW_H_STAT 8'h0C
`define PMW_H_RDATA 8'h10
`define PMW_H_TEST 8'h14
`endif

// [inc/pmw_pkg.sv]
// Types shared by the device end and the host end.
// Assumes pmw_consts.svh for numeric constants.
package pmw_pkg;
  // Operating mode, Gray along standby, normal, sleep
  typedef enum logic [1:0] {
    PMW_STANDBY = 2'h0,
    PMW_NORMAL = 2'h1,
    PMW_SLEEP = 2'h3
  } pmw_mode_t;
  // Host sequencer state
  typedef enum logic [1:0] {
    PMW_H_IDLE = 2'h0,
    PMW_H_PULSE = 2'h1,
    PMW_H_WAIT = 2'h3
  } pmw_hstate_t;
endpackage

// [inc/pmw_if.sv]
// Pins and parallel register link between the device and its host.
// Assumes pull-ups on the open-drain and two-way pins.
`timescale 1ns/1ns
interface pmw_if;
  logic rst_pin;
  logic wkrq_out, wkrq_oe;
  logic irq_out, irq_oe, irq_host_out, irq_host_oe;
  logic gio_a_out, gio_a_oe, gio_a_host_out, gio_a_host_oe;
  logic gpo_b_out, gpo_b_oe;
  logic regulator_enable_out;
  logic reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic wkrq_level, irq_level, gio_a_level, gpo_b_level;
  // Wired levels, undriven pins pulled high
  assign wkrq_level = wkrq_oe ? wkrq_out : 1'b1;
  assign irq_level = irq_oe ? irq_out : (irq_host_oe ? irq_host_out : 1'b1);
  assign gio_a_level = gio_a_oe ? gio_a_out : (gio_a_host_oe ? gio_a_host_out : 1'b1);
  assign gpo_b_level = gpo_b_oe ? gpo_b_out : 1'b1;
  modport device (input rst_pin, irq_level, gio_a_level, reg_wr, reg_rd, reg_addr, reg_wdata,
    output wkrq_out, wkrq_oe, irq_out, irq_oe, gio_a_out, gio_a_oe, gpo_b_out, gpo_b_oe,
    regulator_enable_out, reg_rdata);
  modport host (output rst_pin, irq_host_out, irq_host_oe, gio_a_host_out, gio_a_host_oe,
    reg_wr, reg_rd, reg_addr, reg_wdata,
    input wkrq_level, irq_level, gpo_b_level, regulator_enable_out, reg_rdata);
endinterface // pmw_if

// [core/pmw_sync.sv]
// Two flip-flop synchroniser for pin levels.
// Assumes inputs asynchronous to clock.
`timescale 1ns/1ns
module pmw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // ==========================================
  // Stages
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // pmw_sync

// [core/pmw_host.sv]
// Host end: issues register accesses, pin reset and test pin drives.
// Assumes software on a plain strobe port with one-cycle read data.
`timescale 1ns/1ns
`include "pmw_consts.svh"
module pmw_host import pmw_pkg::*; #(
  parameter int RST_WAIT_CYC = `PMW_RST_WAIT_CYC,
  parameter int PULSE_CYC = `PMW_HOST_PULSE
) (
  input wire logic clock,
  input wire logic rst_n,
  pmw_if.host pins,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  pmw_hstate_t state;
  logic [15:0] cnt;
  logic [15:0] dev_addr;
  logic [31:0] dev_wdata, dev_rdata;
  logic rd_pend, refused, wkrq_s, irq_s, gpb_s, busy;
  logic [3:0] test_drv;

  pmw_sync #(.W(3), .INIT(3'h7)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({pins.wkrq_level, pins.irq_level, pins.gpo_b_level}),
    .q({wkrq_s, irq_s, gpb_s})
  );

  assign busy = (state != PMW_H_IDLE);

  // ==========================================
  // Reset pulse and settle wait
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= PMW_H_IDLE;
      cnt <= 16'h0000;
      pins.rst_pin <= 1'b0;
    end else begin
      case (state)
        PMW_H_IDLE: begin
          if (wr && addr == `PMW_H_CMD && wdata[2]) begin
            state <= PMW_H_PULSE;
            pins.rst_pin <= 1'b1;
            cnt <= 16'h0000;
          end
        end
        PMW_H_PULSE: begin
          cnt <= cnt + 16'h0001;
          if (32'(cnt) >= PULSE_CYC - 1) begin
            state <= PMW_H_WAIT;
            pins.rst_pin <= 1'b0;
            cnt <= 16'h0000;
          end
        end
        PMW_H_WAIT: begin
          cnt <= cnt + 16'h0001;
          if (32'(cnt) >= RST_WAIT_CYC - 1) begin
            state <= PMW_H_IDLE;
          end
        end
        default: state <= PMW_H_IDLE;
      endcase
    end
  end

  // ==========================================
  // Software registers and device strobes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dev_addr <= 16'h0000;
      dev_wdata <= 32'h0000_0000;
      dev_rdata <= 32'h0000_0000;
      test_drv <= 4'h0;
      refused <= 1'b0;
      rd_pend <= 1'b0;
      pins.reg_wr <= 1'b0;
      pins.reg_rd <= 1'b0;
      pins.reg_addr <= 16'h0000;
      pins.reg_wdata <= 32'h0000_0000;
    end else begin
      pins.reg_wr <= 1'b0;
      pins.reg_rd <= 1'b0;
      rd_pend <= pins.reg_rd;
      if (rd_pend) begin
        dev_rdata <= pins.reg_rdata;
      end
      if (wr && addr == `PMW_H_ADDR) begin
        dev_addr <= wdata[15:0];
      end
      if (wr && addr == `PMW_H_WDATA) begin
        dev_wdata <= wdata;
      end
      if (wr && addr == `PMW_H_TEST) begin
        test_drv <= wdata[3:0];
      end
      if (wr && addr == `PMW_H_CMD && (wdata[0] || wdata[1])) begin
        if (busy) begin
          refused <= 1'b1;
        end else begin
          pins.reg_wr <= wdata[0];
          pins.reg_rd <= ~wdata[0];
          pins.reg_addr <= dev_addr;
          pins.reg_wdata <= dev_wdata;
        end
      end else if (rd && addr == `PMW_H_STAT) begin
        refused <= 1'b0;
      end
    end
  end

  // Test drives of interrupt pin and pin A
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pins.irq_host_oe <= 1'b0;
      pins.irq_host_out <= 1'b1;
      pins.gio_a_host_oe <= 1'b0;
      pins.gio_a_host_out <= 1'b1;
    end else begin
      pins.irq_host_oe <= test_drv[0];
      pins.irq_host_out <= test_drv[1];
      pins.gio_a_host_oe <= test_drv[2];
      pins.gio_a_host_out <= test_drv[3];
    end
  end

  // ==========================================
  // Read port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `PMW_H_ADDR: rdata <= {16'h0000, dev_addr};
        `PMW_H_WDATA: rdata <= dev_wdata;
        `PMW_H_STAT: rdata <= {26'h0, pins.regulator_enable_out, gpb_s, irq_s, wkrq_s,
          refused, busy};
        `PMW_H_RDATA: rdata <= dev_rdata;
        `PMW_H_TEST: rdata <= {28'h0, test_drv};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule // pmw_host

// [dv/pmw_checker_assertions.sv]
// Concurrent checks on the pins and register link between the two ends.
// Assumes instantiation beside the interface, each signal fed by name.
`timescale 1ns/1ns
module pmw_checker #(
  parameter int WAIT = 20
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rst_pin,
  input wire logic wkrq_out,
  input wire logic wkrq_oe,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic regulator_enable_out,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  int quiet;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Cycles since the reset pin was last high, saturating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) quiet <= WAIT;
    else if (rst_pin) quiet <= 0;
    else if (quiet < WAIT) quiet <= quiet + 1;
  end
  // ==========================================
  // Properties
  strobe_excl_a: assert property (!(reg_wr && reg_rd))
    else $error("read and write strobes together");
  strobe_pulse_a: assert property ((reg_wr || reg_rd) |=> !(reg_wr || reg_rd))
    else $error("register strobe longer than one cycle");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  pulse_len_a: assert property ($rose(rst_pin) |-> rst_pin[*8] ##1 !rst_pin)
    else $error("reset pin pulse length wrong");
  reset_wait_a: assert property ((reg_wr || reg_rd) |-> quiet >= WAIT - 2)
    else $error("register access too soon after pin reset");
  reg_hold_a: assert property ((rst_pin && regulator_enable_out) |=> regulator_enable_out)
    else $error("regulator enable toggled in pin reset");
  reg_restore_a: assert property ($fell(rst_pin) |-> ##[1:8] regulator_enable_out)
    else $error("regulator enable not on after pin reset");
  wake_reset_a: assert property ($fell(rst_pin) |-> ##[1:8] (wkrq_oe && !wkrq_out))
    else $error("wake request not asserted after pin reset");
  irq_drain_a: assert property (irq_oe |-> !irq_out)
    else $error("interrupt pin driven high");
  sleep_mute_a: assert property ((!regulator_enable_out && reg_rd) |=> reg_rdata == 32'h0)
    else $error("register answered while asleep");
endmodule // pmw_checker

// [dv/pin_mode_and_wake_control_bench.sv]
// Bench driving the host port and device inputs of both joined ends.
// Assumes the design, interface and checker are compiled first.
`timescale 1ns/1ns
`include "pmw_consts.svh"
module pin_mode_and_wake_control_bench import pmw_pkg::*;;
  logic clock, rst_n, wr, rd, bus_wake_pattern, local_wake_flag, wake_error_flag;
  logic ctrl_irq_n, wd_expire, logic_io_supply, xcvr_rx_out, core_tx_out;
  logic test_en, xcvr_tx_in, core_rx_in, watchdog_kick_bit;
  logic [7:0] addr, fault_b;
  logic [3:0] fault_a;
  logic [31:0] wdata, rdata, got;
  logic [1:0] watchdog_action_sel;
  logic [79:0] rows [5];
  pmw_mode_t mode;
  int num_errors, checks, kicks;
  pmw_if pins();
  pmw_device #(.RST_MIN_PULSE(4)) pmw_device_inst (.clock(clock), .rst_n(rst_n), .pins(pins),
    .bus_wake_pattern(bus_wake_pattern), .local_wake_flag(local_wake_flag),
    .wake_error_flag(wake_error_flag), .fault_a(fault_a), .fault_b(fault_b),
    .ctrl_irq_n(ctrl_irq_n), .wd_expire(wd_expire), .logic_io_supply(logic_io_supply),
    .xcvr_rx_out(xcvr_rx_out), .core_tx_out(core_tx_out), .mode(mode), .test_en(test_en),
    .xcvr_tx_in(xcvr_tx_in), .core_rx_in(core_rx_in),
    .watchdog_action_sel(watchdog_action_sel), .watchdog_kick_bit(watchdog_kick_bit));
  pmw_host #(.RST_WAIT_CYC(20), .PULSE_CYC(8)) pmw_host_inst (.clock(clock), .rst_n(rst_n),
    .pins(pins), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  pmw_checker #(.WAIT(20)) pmw_checker_inst (.clock(clock), .rst_n(rst_n),
    .rst_pin(pins.rst_pin), .wkrq_out(pins.wkrq_out), .wkrq_oe(pins.wkrq_oe),
    .irq_out(pins.irq_out), .irq_oe(pins.irq_oe),
    .regulator_enable_out(pins.regulator_enable_out), .reg_wr(pins.reg_wr),
    .reg_rd(pins.reg_rd), .reg_rdata(pins.reg_rdata));
  // ==========================================
  // Clock, kick counter and watchdog
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Counts one-cycle watchdog restart pulses
  always @(posedge clock) if (watchdog_kick_bit === 1'b1) kicks++;
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    print_verdict;
  end
  // ==========================================
  // Tasks
  task print_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task hw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task hr(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    got = rdata;
  endtask
  task dw(input logic [15:0] a, input logic [31:0] d);
    hw(`PMW_H_ADDR, {16'h0, a});
    hw(`PMW_H_WDATA, d);
    hw(`PMW_H_CMD, 32'h1);
    repeat (6) @(negedge clock);
  endtask
  task dr(input logic [15:0] a);
    hw(`PMW_H_ADDR, {16'h0, a});
    hw(`PMW_H_CMD, 32'h2);
    repeat (3) @(posedge clock);
    hr(`PMW_H_RDATA);
  endtask
  // Pin reset then the full busy span of the host
  task prst;
    hw(`PMW_H_CMD, 32'h4);
    repeat (40) @(negedge clock);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {rst_n, wr, rd, addr, wdata, bus_wake_pattern, local_wake_flag, wake_error_flag} = '0;
    {fault_a, fault_b, wd_expire, num_errors, checks, kicks} = '0;
    {ctrl_irq_n, logic_io_supply, xcvr_rx_out, core_tx_out} = 4'hF;
    rows[0] = {`PMW_CFG_OFF, 32'h0000_4100, 32'h0000_4100};
    rows[1] = {`PMW_MODE_OFF, 32'h0000_0001, 32'h0000_0001};
    rows[2] = {`PMW_MASK_A_OFF, 32'h0000_0000, 32'h0000_0000};
    rows[3] = {`PMW_MASK_B_OFF, 32'h0000_00F0, 32'h0000_00F0};
    rows[4] = {16'h0840, 32'hDEAD_BEEF, 32'h0000_0000};
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk("wkrq", 0, 32'(pins.wkrq_level));
    dr(`PMW_STAT_A_OFF);
    chk("stat_a", 32'h8, got);
    dw(`PMW_STAT_A_OFF, 32'h8);
    chk("wkrq latched", 0, 32'(pins.wkrq_level));
    $display("test reset end");
    for (int i = 0; i < 5; i++) begin
      dw(rows[i][79:64], rows[i][63:32]);
      dr(rows[i][79:64]);
      chk("row", rows[i][31:0], got);
    end
    chk("wkrq irq", 1, 32'(pins.wkrq_level));
    $display("test rows end");
    dw(`PMW_MASK_A_OFF, 32'h2);
    @(posedge clock) local_wake_flag <= 1'b1;
    @(posedge clock) local_wake_flag <= 1'b0;
    repeat (4) @(negedge clock);
    chk("wkrq masked", 1, 32'(pins.wkrq_level));
    dw(`PMW_MASK_A_OFF, 32'h0);
    chk("wkrq unmasked", 0, 32'(pins.wkrq_level));
    dw(`PMW_STAT_A_OFF, 32'h2);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) {wake_error_flag, local_wake_flag, bus_wake_pattern} <= 3'b1 << i;
      @(posedge clock) {wake_error_flag, local_wake_flag, bus_wake_pattern} <= 3'b0;
      repeat (4) @(negedge clock);
      chk("wkrq flag", 0, 32'(pins.wkrq_level));
      dw(`PMW_STAT_A_OFF, 32'h7);
      chk("wkrq clear", 1, 32'(pins.wkrq_level));
    end
    $display("test wake end");
    dw(`PMW_CFG_OFF, 32'h0080_0900);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) {fault_a[0], fault_b[4], fault_b[0]} <= 3'b1 << i;
      @(posedge clock) {fault_a[0], fault_b[4], fault_b[0]} <= 3'b0;
      repeat (4) @(negedge clock);
      chk("irq", i == 1, 32'(pins.irq_level));
      chk("pin b", i == 1, 32'(pins.gpo_b_level));
      chk("pin a", i == 1, 32'(pins.gio_a_level));
      dw(`PMW_STAT_B_OFF, 32'h11);
      dw(`PMW_STAT_A_OFF, 32'h100);
      chk("irq clear", 1, 32'(pins.irq_level));
    end
    dw(`PMW_CFG_OFF, 32'h0004_8000);
    hw(`PMW_H_TEST, 32'hC);
    hw(`PMW_H_TEST, 32'h4);
    repeat (6) @(negedge clock);
    chk("kicks", 2, kicks);
    hw(`PMW_H_TEST, 32'h0);
    $display("test pins end");
    dw(`PMW_CFG_OFF, 32'h0021_0000);
    chk("watchdog_action_sel", 32'h1, 32'(watchdog_action_sel));
    chk("test en", 1, 32'(test_en));
    hw(`PMW_H_TEST, 32'h7);
    xcvr_rx_out <= 1'b0;
    repeat (6) @(negedge clock);
    chk("test normal", PMW_NORMAL, 32'(mode));
    chk("tx in", 0, 32'(xcvr_tx_in));
    chk("rx shown", 0, 32'(pins.gpo_b_level));
    hw(`PMW_H_TEST, 32'h1);
    repeat (6) @(negedge clock);
    chk("test standby", PMW_STANDBY, 32'(mode));
    hw(`PMW_H_TEST, 32'h4);
    dw(`PMW_CFG_OFF, 32'h0020_0001);
    xcvr_rx_out <= 1'b1;
    core_tx_out <= 1'b0;
    repeat (6) @(negedge clock);
    chk("core rx", 0, 32'(core_rx_in));
    chk("tx shown", 0, 32'(pins.gpo_b_level));
    hw(`PMW_H_TEST, 32'h0);
    dw(`PMW_CFG_OFF, 32'h0000_4000);
    $display("test testmode end");
    dw(`PMW_MODE_OFF, 32'h1);
    prst;
    chk("reset mode", PMW_STANDBY, 32'(mode));
    dr(`PMW_CFG_OFF);
    chk("reset cfg", `PMW_CFG_RST, got);
    dw(`PMW_CFG_OFF, 32'h0008_4000);
    dw(`PMW_MODE_OFF, 32'h3);
    chk("sleep reg", 0, 32'(pins.regulator_enable_out));
    dr(`PMW_CFG_OFF);
    chk("sleep read", 0, got);
    @(posedge clock) bus_wake_pattern <= 1'b1;
    @(posedge clock) bus_wake_pattern <= 1'b0;
    repeat (4) @(negedge clock);
    chk("woken", PMW_STANDBY, 32'(mode));
    dr(`PMW_CFG_OFF);
    chk("kept bit", `PMW_CFG_RST | 32'h0008_0000, got);
    // Wake request on the logic supply waits for that supply
    @(posedge clock) logic_io_supply <= 1'b0;
    repeat (5) @(negedge clock);
    chk("wkrq no supply", 1, 32'(pins.wkrq_level));
    @(posedge clock) logic_io_supply <= 1'b1;
    repeat (5) @(negedge clock);
    chk("wkrq supply", 0, 32'(pins.wkrq_level));
    dw(`PMW_MODE_OFF, 32'h3);
    prst;
    chk("sleep reset", PMW_STANDBY, 32'(mode));
    chk("reg on", 1, 32'(pins.regulator_enable_out));
    $display("test modes end");
    print_verdict;
  end
endmodule // pin_mode_and_wake_control_bench
